// >>> smc_checker.sv
`timescale 1ns/1ps
module smc_checker
   import smc_pkg::*;
#(
   parameter logic [7:0] DETECTOR_PRESENT = 8'h0f  // One bit per fitted speed detector
) (
   input  wire logic        clk,                   // 100 MHz clock
   input  wire logic        nrst,                  // Async reset, active low
   input  wire logic [3:0]  avsAddress,            // Byte address
   input  wire logic        avsRead,               // Read request
   input  wire logic        avsWrite,              // Write request
   input  wire logic [31:0] avsWriteData,          // Write data
   input  wire logic [3:0]  avsByteEnable,         // Byte lanes
   output logic      [31:0] avsReadData,           // Read data
   output logic             avsWaitRequest,        // Stall
   input  wire logic        forwardRotationCmd,    // Forward run
   input  wire logic        reverseRotationCmd,    // Reverse run
   input  wire logic        axisShapeModeCmd,      // Contour control request
   input  wire logic        servoModeCmd,          // Servo mode request
   input  wire logic        spindleSyncCmd,        // Synchronization request
   input  wire logic        orientCmd,             // Orientation request
   input  wire logic        coderOrientCmd,        // Orientation by coder
   input  wire logic        diffSpeedCmd,          // Differential speed
   input  wire logic        slaveModeCmd,          // Slave operation request
   input  wire logic        slaveModeState,        // Slave state from controller
   input  wire logic        incrementalOrientSel,  // Incremental orientation
   input  wire logic        estopContactA,         // Stop contact terminal A
   input  wire logic        estopContactB,         // Stop contact terminal B
   output logic      [7:0]  errorCode,             // Two BCD digits, 00 = none
   output logic             yellowLed,             // Error indicator
   output logic      [2:0]  activeMode,            // Mode being executed
   output logic             emergencyStop          // Stop contact open
);
   import smc_pkg::*;

   typedef struct packed {
      logic [CFG_W-1:0] cfg;
      smc_mode_t        mode;
      logic             incFirst;
      logic             absDone;
      logic             estop;
      logic             yellow;
      logic [7:0]       code;
      logic             waitReq;
      logic [31:0]      rdata;
   } smc_state_t;

   localparam int IDX_W = $clog2(NUM_ERR);

   smc_state_t            st;
   smc_state_t            next_st;
   logic [NUM_ERR-1:0]    cond;
   logic [IDX_W-1:0]      winIdx;
   logic                  winHit;
   logic                  reqStart;
   logic                  reqDone;
   logic                  clearHist;
   logic                  reqContour;
   logic                  reqServo;
   logic                  reqSync;
   logic                  reqOrient;
   logic                  posMode;
   logic [2:0]            reqCount;
   logic [CFG_DET_W-1:0]  detSel;
   logic [CFG_W-1:0]      laneMask;
   logic [31:0]           statusWord;

   // Outputs straight from the state flops
   assign avsReadData    = st.rdata;
   assign avsWaitRequest = st.waitReq;
   assign errorCode      = st.code;
   assign yellowLed      = st.yellow;
   assign activeMode     = st.mode;
   assign emergencyStop  = st.estop;

   // Request decode
   assign reqContour = axisShapeModeCmd;
   assign reqServo   = servoModeCmd;
   assign reqSync    = spindleSyncCmd;
   assign reqOrient  = orientCmd | coderOrientCmd;
   assign reqCount   = 3'(reqContour) + 3'(reqServo) + 3'(reqSync) + 3'(reqOrient);
   assign posMode    = (st.mode == MODE_SERVO) || (st.mode == MODE_ORIENT) || (st.mode == MODE_MAG_ORIENT);
   assign detSel     = st.cfg[CFG_DET_LSB +: CFG_DET_W];

   // Error conditions, bit i stands for code twelve plus i
   always_comb
   begin
      cond     = '0;
      cond[0]  = (st.mode == MODE_SYNC) && (reqContour | reqServo | reqOrient);            // [RULE1]
      cond[1]  = (st.mode == MODE_ORIENT) && (reqContour | reqServo | reqSync);            // [RULE3]
      cond[2]  = forwardRotationCmd & reverseRotationCmd;                                   // [RULE4]
      cond[3]  = st.cfg[CFG_DIFF_PRESENT] & reqContour;                                     // [RULE5]
      cond[4]  = !st.cfg[CFG_DIFF_PRESENT] & diffSpeedCmd;                                  // [RULE6]
      cond[5]  = !DETECTOR_PRESENT[detSel];                                                 // [RULE7]
      cond[6]  = !st.cfg[CFG_CODER_USED] & coderOrientCmd;                                  // [RULE8]
      cond[7]  = (st.mode == MODE_MAG_ORIENT)
                 && (reqContour | reqServo | reqSync | slaveModeCmd | diffSpeedCmd);        // [RULE9]
      cond[8]  = st.cfg[CFG_SLAVE_EN] & (st.cfg[CFG_HIRES_CODER] | st.cfg[CFG_SENSOR_CS]); // [RULE10]
      cond[9]  = posMode & slaveModeCmd;                                                    // [RULE11]
      cond[10] = slaveModeState & (reqServo | reqOrient);                                   // [RULE12]
      cond[11] = !st.cfg[CFG_SLAVE_EN] & slaveModeCmd;                                      // [RULE13]
      cond[12] = st.incFirst & reqOrient & !incrementalOrientSel;                           // [RULE14]
      cond[13] = st.cfg[CFG_SENSOR_CS] & !st.cfg[CFG_AMP_TYPE4];                            // [RULE16]
   end

   smc_prio_enc #(
      .N   (NUM_ERR)
   ) u_prio (
      .vec (cond),
      .idx (winIdx),
      .hit (winHit)
   );

   // Byte lanes of the configuration word
   generate
      for (genvar b = 0; b < CFG_W / 8; b++)
      begin : g_lane
         assign laneMask[b*8 +: 8] = {8{avsByteEnable[b]}};
      end
   endgenerate

   // Status word seen by software
   always_comb
   begin
      statusWord                       = '0;
      statusWord[ST_CODE_LSB +: 8]     = st.code;
      statusWord[ST_YELLOW]            = st.yellow;
      statusWord[ST_MODE_LSB +: 3]     = st.mode;
      statusWord[ST_ESTOP]             = st.estop;
      statusWord[ST_INC_FIRST]         = st.incFirst;
   end

   // Bus handshake: one wait cycle, then a single ready cycle
   assign reqStart  = (avsRead | avsWrite) & st.waitReq;
   assign reqDone   = (avsRead | avsWrite) & !st.waitReq;
   assign clearHist = reqDone & avsWrite & (avsAddress == REG_CTRL)
                      & avsByteEnable[0] & avsWriteData[CTRL_CLR_HIST];

   // Next state
   always_comb
   begin
      next_st         = st;
      next_st.waitReq = !reqStart;
      // Read data settles during the ready cycle; unmapped reads as zero
      if (reqStart && avsRead)
      begin
         case (avsAddress)
            REG_CFG:    next_st.rdata = 32'(st.cfg);
            REG_STATUS: next_st.rdata = statusWord;
            default:    next_st.rdata = 32'h0000_0000;
         endcase
      end
      if (reqDone && avsWrite && (avsAddress == REG_CFG))
      begin
         next_st.cfg = (st.cfg & ~laneMask) | (avsWriteData[CFG_W-1:0] & laneMask);
      end

      // Open contact is a stop; both terminals high means closed
      next_st.estop = !(estopContactA & estopContactB);  // [RULE17]

      // Code follows the live conflict, so it stays until withdrawn
      next_st.code   = winHit ? smcToBcd(ERR_BASE + 5'(winIdx)) : CODE_NONE;  // [RULE19]
      next_st.yellow = winHit;                                                 // [RULE18]

      // Orientation history for the incremental check
      if (clearHist)
      begin
         next_st.incFirst = 1'b0;
         next_st.absDone  = 1'b0;
      end

      // Mode sequencing; a conflicting request is never entered
      case (st.mode)
         MODE_NORMAL:
         begin
            if (!st.estop && !winHit && reqCount == 3'd1)  // [RULE19]
            begin
               if (reqContour)
                  next_st.mode = MODE_CONTOUR;
               else if (reqServo)
                  next_st.mode = MODE_SERVO;
               else if (reqSync)
                  next_st.mode = MODE_SYNC;
               else
               begin
                  next_st.mode = (st.cfg[CFG_MAG_ORIENT] && !coderOrientCmd) ? MODE_MAG_ORIENT : MODE_ORIENT;
                  if (incrementalOrientSel && !st.absDone)
                     next_st.incFirst = 1'b1;  // [RULE14]
                  if (!incrementalOrientSel)
                     next_st.absDone = 1'b1;
               end
            end
         end
         MODE_CONTOUR:    if (!reqContour) next_st.mode = MODE_NORMAL;
         MODE_SERVO:      if (!reqServo)   next_st.mode = MODE_NORMAL;
         MODE_SYNC:       if (!reqSync)    next_st.mode = MODE_NORMAL;
         MODE_ORIENT,
         MODE_MAG_ORIENT: if (!reqOrient)  next_st.mode = MODE_NORMAL;
         default:         next_st.mode = MODE_NORMAL;
      endcase
      // A stop drops whatever mode was running
      if (st.estop)
         next_st.mode = MODE_NORMAL;  // [RULE17]
   end

   // State register
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st          <= '0;
         st.cfg      <= CFG_RESET;
         st.mode     <= MODE_NORMAL;
         st.estop    <= 1'b1;
         st.waitReq  <= 1'b1;
         st.code     <= CODE_NONE;
      end
      else
         st <= next_st;
   end

   // Guards on the checking logic
   a_sync_conflict: assert property (@(posedge clk) disable iff (!nrst)  // [RULE1]
      (st.mode == MODE_SYNC && reqServo) |=> (errorCode == smcToBcd(ERR_BASE)) && yellowLed)
      else $error("sync conflict did not give code 12");

   a_orient_conflict: assert property (@(posedge clk) disable iff (!nrst)  // [RULE3]
      (st.mode == MODE_ORIENT && reqSync && !cond[0]) |=> errorCode == smcToBcd(ERR_BASE + 5'd1))
      else $error("orientation conflict did not give code 13");

   a_both_directions: assert property (@(posedge clk) disable iff (!nrst)  // [RULE4]
      (forwardRotationCmd && reverseRotationCmd && cond[1:0] == 2'b00)
      |=> errorCode == smcToBcd(ERR_BASE + 5'd2))
      else $error("both directions did not give code 14");

   a_diff_contour: assert property (@(posedge clk) disable iff (!nrst)  // [RULE5]
      (st.cfg[CFG_DIFF_PRESENT] && reqContour) |=> yellowLed)
      else $error("contour with differential function not flagged");

   a_diff_absent: assert property (@(posedge clk) disable iff (!nrst)  // [RULE6]
      (!st.cfg[CFG_DIFF_PRESENT] && diffSpeedCmd && cond[3:0] == 4'h0)
      |=> errorCode == smcToBcd(ERR_BASE + 5'd4))
      else $error("differential without function did not give code 16");

   a_coder_orient: assert property (@(posedge clk) disable iff (!nrst)  // [RULE8]
      (!st.cfg[CFG_CODER_USED] && coderOrientCmd && st.mode == MODE_NORMAL) |=> st.mode == MODE_NORMAL)
      else $error("coder orientation entered without position coder");

   a_slave_disabled: assert property (@(posedge clk) disable iff (!nrst)  // [RULE13]
      (!st.cfg[CFG_SLAVE_EN] && slaveModeCmd) |=> yellowLed && errorCode != CODE_NONE)
      else $error("slave command with slave disabled not flagged");

   a_inc_then_abs: assert property (@(posedge clk) disable iff (!nrst)  // [RULE14]
      (st.incFirst && reqOrient && !incrementalOrientSel && cond[11:0] == 12'h000)
      |=> errorCode == smcToBcd(ERR_BASE + 5'd12))
      else $error("absolute after incremental did not give code 24");

   a_cfg_type4: assert property (@(posedge clk) disable iff (!nrst)  // [RULE16]
      (cond[13] && cond[12:0] == 13'h0000) |=> errorCode == smcToBcd(ERR_BASE + 5'd13))
      else $error("sensor contour on wrong amplifier did not give code 25");

   a_estop_contact: assert property (@(posedge clk) disable iff (!nrst)  // [RULE17]
      !(estopContactA && estopContactB) |=> emergencyStop ##1 activeMode == MODE_NORMAL)
      else $error("open contact did not stop");

   a_reject_hold: assert property (@(posedge clk) disable iff (!nrst)  // [RULE19]
      (st.mode == MODE_NORMAL && winHit) |=> activeMode == MODE_NORMAL && yellowLed)
      else $error("conflicting command was entered");

   a_clear_on_withdraw: assert property (@(posedge clk) disable iff (!nrst)  // [RULE19]
      (!winHit) |=> errorCode == CODE_NONE && !yellowLed)
      else $error("code stayed after withdrawal");

endmodule // smc_checker

// >>> smc_ladder_model.sv
`timescale 1ns/1ps
// Ladder controller stand-in: mode command levels change only on a clock edge
module smc_ladder_model (
   input  wire logic        clk,                   // 100 MHz clock
   input  wire logic        nrst,                  // Async reset, active low
   input  wire logic [11:0] cmdWord,               // Wanted command levels
   output logic             forwardRotationCmd,    // Forward run
   output logic             reverseRotationCmd,    // Reverse run
   output logic             axisShapeModeCmd,      // Contour request
   output logic             servoModeCmd,          // Servo request
   output logic             spindleSyncCmd,        // Synchronization request
   output logic             orientCmd,             // Orientation request
   output logic             coderOrientCmd,        // Coder orientation
   output logic             diffSpeedCmd,          // Differential speed
   output logic             slaveModeCmd,          // Slave request
   output logic             slaveModeState,        // Slave state
   output logic             incrementalOrientSel,  // Incremental orientation
   output logic             estopContactA,         // Contact terminal A
   output logic             estopContactB          // Contact terminal B
);
   logic [11:0] held;

   // Levels are held whole; another mode can be asked while one is still held
   // Absolute orientation first unless a scenario asks otherwise
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         held <= 12'h000;
      else
         held <= cmdWord;
   end

   assign {incrementalOrientSel, slaveModeState, slaveModeCmd, diffSpeedCmd, coderOrientCmd,
           orientCmd, spindleSyncCmd, servoModeCmd, axisShapeModeCmd, reverseRotationCmd,
           forwardRotationCmd} = held[10:0];
   // Open contact: terminal B no longer follows terminal A
   assign estopContactA = 1'b1;
   assign estopContactB = ~held[11];
endmodule // smc_ladder_model

// >>> smc_pkg.sv
// Operation
// [RULE1] Mode request during synchronization gives 12
// [RULE2] Controller cancels a mode before requesting another
// [RULE3] Mode request during orientation gives 13
// [RULE4] Forward and reverse together give 14
// [RULE5] Contour request with differential speed gives 15
// [RULE6] Differential command without the function gives 16
// [RULE7] Absent speed detector selected gives 17
// [RULE8] Coder orientation without position coder gives 18
// [RULE9] Request during magnetic orientation gives 19
// [RULE10] Slave with high-res coder or sensor gives 20
// [RULE11] Slave command during position control gives 21
// [RULE12] Position request while slave state gives 22
// [RULE13] Slave command with slave disabled gives 23
// [RULE14] Absolute orientation after incremental first gives 24
// [RULE15] Controller orients absolute before using incremental
// [RULE16] Sensor contour on non type-4 amplifier gives 25
// [RULE17] Open stop contact means emergency stop
// [RULE18] Two-digit code with yellow lamp, not to controller
// [RULE19] Reject offending command, hold code until withdrawn
package smc_pkg;

   // Register byte addresses
   localparam logic [3:0] REG_CFG    = 4'h0;
   localparam logic [3:0] REG_CTRL   = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;

   // Configuration word fields
   localparam int CFG_DIFF_PRESENT = 0;  // Differential speed function fitted
   localparam int CFG_CODER_USED   = 1;  // Position coder in use
   localparam int CFG_HIRES_CODER  = 2;  // High-resolution coder in use
   localparam int CFG_SLAVE_EN     = 3;  // Slave operation enabled
   localparam int CFG_SENSOR_CS    = 4;  // Contour control by sensor
   localparam int CFG_AMP_TYPE4    = 5;  // Amplifier is type 4
   localparam int CFG_MAG_ORIENT   = 6;  // Orientation by magnetic sensor
   localparam int CFG_DET_LSB      = 8;  // Speed detector select, 3 bits
   localparam int CFG_DET_W        = 3;
   localparam int CFG_W            = 16;
   localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;

   // Control and status fields
   localparam int CTRL_CLR_HIST = 0;     // Write 1 clears orientation history
   localparam int ST_CODE_LSB   = 0;
   localparam int ST_YELLOW     = 8;
   localparam int ST_MODE_LSB   = 9;
   localparam int ST_ESTOP      = 12;
   localparam int ST_INC_FIRST  = 13;

   // Error numbering
   localparam int          NUM_ERR  = 14;
   localparam logic [4:0]  ERR_BASE = 5'h0c;
   localparam logic [7:0]  CODE_NONE = 8'h00;

   typedef enum logic [2:0] {
      MODE_NORMAL,
      MODE_CONTOUR,
      MODE_SERVO,
      MODE_SYNC,
      MODE_ORIENT,
      MODE_MAG_ORIENT
   } smc_mode_t;

   // Binary error number to two decimal digits
   function automatic logic [7:0] smcToBcd(input logic [4:0] n);
      logic [4:0] tens;
      logic [4:0] ones;
      tens = n / 5'd10;
      ones = n - 5'(tens * 5'd10);
      return {tens[3:0], ones[3:0]};
   endfunction

endpackage

// >>> smc_prio_enc.sv
`timescale 1ns/1ps
// Lowest set bit wins; yields its index
module smc_prio_enc #(
   parameter int N = 14
) (
   input  wire logic [N-1:0]         vec,   // Request vector
   output logic      [$clog2(N)-1:0] idx,   // Index of winner
   output logic                      hit    // Any bit set
);
   // Scan from the top so the lowest index is written last
   always_comb
   begin
      idx = '0;
      hit = 1'b0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (vec[i])
         begin
            idx = ($clog2(N))'(i);
            hit = 1'b1;
         end
      end
   end
endmodule // smc_prio_enc

// >>> spindle_mode_conflict_checker_test.sv
`timescale 1ns/1ps
module spindle_mode_conflict_checker_test;
   import smc_pkg::*;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [3:0]  avsAddress = 4'h0;
   logic        avsRead = 1'b0;
   logic        avsWrite = 1'b0;
   logic [31:0] avsWriteData = 32'h0;
   logic [3:0]  avsByteEnable = 4'h0;
   logic [31:0] avsReadData;
   logic        avsWaitRequest;
   logic [11:0] cmd = 12'h000;
   logic        fwd, rev, cont, reverse_rotation_cmd, sync, ori, cori, dif, slave_mode_cmd, slave_mode_state, inc, ea, eb;
   logic [7:0]  errorCode;
   logic        yellowLed;
   logic [2:0]  activeMode;
   logic        emergencyStop;
   int          n_fail = 0;
   int          compares = 0;
   int          cycles = 0;

   smc_ladder_model ladder (.clk(clk), .nrst(nrst), .cmdWord(cmd), .forwardRotationCmd(fwd),
      .reverseRotationCmd(rev), .axisShapeModeCmd(cont), .servoModeCmd(reverse_rotation_cmd), .spindleSyncCmd(sync),
      .orientCmd(ori), .coderOrientCmd(cori), .diffSpeedCmd(dif), .slaveModeCmd(slave_mode_cmd),
      .slaveModeState(slave_mode_state), .incrementalOrientSel(inc), .estopContactA(ea), .estopContactB(eb));

   smc_checker #(.DETECTOR_PRESENT(8'h0f)) dut (.clk(clk), .nrst(nrst), .avsAddress(avsAddress),
      .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
      .avsByteEnable(avsByteEnable), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
      .forwardRotationCmd(fwd), .reverseRotationCmd(rev), .axisShapeModeCmd(cont),
      .servoModeCmd(reverse_rotation_cmd), .spindleSyncCmd(sync), .orientCmd(ori), .coderOrientCmd(cori),
      .diffSpeedCmd(dif), .slaveModeCmd(slave_mode_cmd), .slaveModeState(slave_mode_state), .incrementalOrientSel(inc),
      .estopContactA(ea), .estopContactB(eb), .errorCode(errorCode), .yellowLed(yellowLed),
      .activeMode(activeMode), .emergencyStop(emergencyStop));

   // Clock at 100 MHz
   always #5 clk = ~clk;

   task automatic final_report();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Hang guard, far above the few hundred cycles the tests take
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_fail++;
         final_report();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // One Avalon access; request held until the rising edge that sees waitrequest low
   // Only the hang guard ends a wait that never finishes
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      avsAddress <= a;
      avsWrite <= wr;
      avsRead <= ~wr;
      avsWriteData <= d;
      avsByteEnable <= 4'hf;
      do
         @(negedge clk);
      while (avsWaitRequest !== 1'b0);
      @(posedge clk);
      q = avsReadData;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, exp, "read");
   endtask

   // Apply command levels, then compare code, lamp and mode two edges later
   task automatic step(input logic [11:0] v, input logic [7:0] code, input logic [2:0] mode);
      @(posedge clk);
      cmd <= v;
      repeat (2) @(posedge clk);
      #1;
      check({24'h0, errorCode}, {24'h0, code}, "code");
      check({29'h0, activeMode}, {29'h0, mode}, "mode");
      check({31'h0, yellowLed}, {31'h0, code != 8'h00}, "lamp");
   endtask

   initial
   begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      #1;
      check({31'h0, emergencyStop}, 32'h1, "stop in reset");
      repeat (2) @(posedge clk);
      #1;
      check({31'h0, emergencyStop}, 32'h0, "stop after reset");
      rd(REG_CFG, 32'h0);
      rd(4'hc, 32'h0);
      wr(REG_STATUS, 32'hffff);
      rd(REG_STATUS, 32'h0);
      step(12'h003, 8'h14, MODE_NORMAL);
      rd(REG_STATUS, 32'h114);
      step(12'h001, 8'h00, MODE_NORMAL);
      step(12'h080, 8'h16, MODE_NORMAL);
      step(12'h100, 8'h23, MODE_NORMAL);
      step(12'h040, 8'h18, MODE_NORMAL);
      step(12'h000, 8'h00, MODE_NORMAL);
      $display("test single commands done");
      step(12'h004, 8'h00, MODE_CONTOUR);
      step(12'h000, 8'h00, MODE_NORMAL);
      step(12'h010, 8'h00, MODE_SYNC);
      step(12'h018, 8'h12, MODE_SYNC);
      step(12'h014, 8'h12, MODE_SYNC);
      step(12'h030, 8'h12, MODE_SYNC);
      step(12'h000, 8'h00, MODE_NORMAL);
      step(12'h020, 8'h00, MODE_ORIENT);
      step(12'h024, 8'h13, MODE_ORIENT);
      step(12'h028, 8'h13, MODE_ORIENT);
      step(12'h030, 8'h13, MODE_ORIENT);
      step(12'h000, 8'h00, MODE_NORMAL);
      wr(REG_CFG, 32'h8);
      step(12'h008, 8'h00, MODE_SERVO);
      step(12'h108, 8'h21, MODE_SERVO);
      step(12'h200, 8'h00, MODE_NORMAL);
      step(12'h208, 8'h22, MODE_NORMAL);
      step(12'h220, 8'h22, MODE_NORMAL);
      step(12'h000, 8'h00, MODE_NORMAL);
      $display("test mode conflicts done");
      wr(REG_CFG, 32'h1);
      step(12'h004, 8'h15, MODE_NORMAL);
      wr(REG_CFG, 32'h41);
      step(12'h020, 8'h00, MODE_MAG_ORIENT);
      step(12'h0a0, 8'h19, MODE_MAG_ORIENT);
      step(12'h000, 8'h00, MODE_NORMAL);
      wr(REG_CFG, 32'h42);
      step(12'h040, 8'h00, MODE_ORIENT);
      step(12'h000, 8'h00, MODE_NORMAL);
      wr(REG_CFG, 32'hc);
      step(12'h000, 8'h20, MODE_NORMAL);
      wr(REG_CFG, 32'h18);
      step(12'h000, 8'h20, MODE_NORMAL);
      wr(REG_CFG, 32'h10);
      step(12'h000, 8'h25, MODE_NORMAL);
      wr(REG_CFG, 32'h30);
      step(12'h000, 8'h00, MODE_NORMAL);
      wr(REG_CFG, 32'h700);
      step(12'h000, 8'h17, MODE_NORMAL);
      wr(REG_CFG, 32'h300);
      step(12'h000, 8'h00, MODE_NORMAL);
      rd(REG_CFG, 32'h300);
      $display("test configuration done");
      wr(REG_CFG, 32'h0);
      wr(REG_CTRL, 32'h1);
      step(12'h420, 8'h00, MODE_ORIENT);
      step(12'h000, 8'h00, MODE_NORMAL);
      rd(REG_STATUS, 32'h2000);
      step(12'h020, 8'h24, MODE_NORMAL);
      step(12'h000, 8'h00, MODE_NORMAL);
      wr(REG_CTRL, 32'h1);
      rd(REG_STATUS, 32'h0);
      step(12'h020, 8'h00, MODE_ORIENT);
      step(12'h000, 8'h00, MODE_NORMAL);
      $display("test orientation history done");
      step(12'h008, 8'h00, MODE_SERVO);
      @(posedge clk);
      cmd <= 12'h808;
      repeat (2) @(posedge clk);
      #1;
      check({31'h0, emergencyStop}, 32'h1, "stop open");
      @(posedge clk);
      #1;
      check({29'h0, activeMode}, 32'h0, "stop mode");
      step(12'h000, 8'h00, MODE_NORMAL);
      check({31'h0, emergencyStop}, 32'h0, "stop closed");
      $display("test emergency stop done");
      final_report();
   end
endmodule // spindle_mode_conflict_checker_test
